// ---- common/isr_pkg.sv ----
// Constants, selects and carriers for the instrument status reporting block.
// Assumes a single 50 MHz clock shared by all users of the package.
package isr_pkg;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int OQ_DEPTH = 16;
    // Implemented bits of each register
    localparam logic [15:0] NORM_MASK = 16'h0D21;
    localparam logic [15:0] ABN_MASK = 16'h4617;
    localparam logic [7:0] STD_MASK = 8'hBD;
    localparam logic [7:0] SRE_MASK = 8'hB8;
    // Normal-operation condition bits
    localparam int NORM_CAL_BIT = 0;
    localparam int NORM_TRIGGER_WAIT_BIT = 5;
    localparam int NORM_CONSTANT_VOLTAGE_BIT = 8;
    localparam int NORM_POS_CURRENT_BIT = 10;
    localparam int NORM_NEG_CURRENT_BIT = 11;
    // Abnormal-operation condition bits
    localparam int ABN_OVERVOLTAGE_BIT = 0;
    localparam int ABN_OVERCURRENT_BIT = 1;
    localparam int ABN_FUSE_BIT = 2;
    localparam int ABN_OVERTEMP_BIT = 4;
    localparam int ABN_INHIBIT_BIT = 9;
    localparam int ABN_UNREG_BIT = 10;
    localparam int ABN_OVERLOAD_BIT = 14;
    // Standard event and status byte bits
    localparam int POWER_ON_FLAG_BIT = 7;
    localparam int STATUS_ABNORMAL_BIT = 3;
    localparam int STATUS_MESSAGE_BIT = 4;
    localparam int STATUS_EVENT_BIT = 5;
    localparam int STATUS_SERVICE_BIT = 6;
    localparam int STATUS_OPERATION_BIT = 7;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [7:0] ZERO8 = 8'h00;

    typedef enum logic [3:0] {
        SEL_NORM_COND, SEL_NORM_RISE, SEL_NORM_FALL, SEL_NORM_EVENT,
        SEL_NORM_EN, SEL_ABN_COND, SEL_ABN_RISE, SEL_ABN_FALL,
        SEL_ABN_EVENT, SEL_ABN_EN, SEL_STD_EVENT, SEL_STD_EN,
        SEL_STATUS, SEL_SRE, SEL_OQ_READ, SEL_POLL
    } isr_sel_t;

    typedef struct packed {
        logic valid;
        logic write;
        isr_sel_t sel;
        logic [DATA_W-1:0] wdata;
    } isr_cmd_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } isr_rsp_t;
endpackage

// ---- src/isr_top.sv ----
// Status reporting and service request logic of a programmable dc source.
// Assumes the command parser issues one register access per cmd pulse and
// that all condition and event inputs are synchronous to SYS_CLK_I.
`timescale 1ns/100ps

module isr_group #(
    parameter logic [15:0] MASK = 16'hFFFF
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] cond_i,
    input wire logic wr_rise_i,
    input wire logic wr_fall_i,
    input wire logic wr_en_i,
    input wire logic [15:0] wdata_i,
    input wire logic rd_evt_i,
    output logic [15:0] cond_o,
    output logic [15:0] rise_o,
    output logic [15:0] fall_o,
    output logic [15:0] evt_o,
    output logic [15:0] en_o,
    output logic summary_o
);
    logic [15:0] cond_q;
    logic [15:0] rise_q;
    logic [15:0] fall_q;
    logic [15:0] evt_q;
    logic [15:0] en_q;
    logic [15:0] edges;

    // Condition sampled each clock, previous sample kept for edges
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cond_q <= 16'h0000;
        end else begin
            cond_q <= cond_i & MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rise_q <= 16'h0000;
            fall_q <= 16'h0000;
            en_q <= 16'h0000;
        end else begin
            if (wr_rise_i) begin
                rise_q <= wdata_i & MASK;
            end
            if (wr_fall_i) begin
                fall_q <= wdata_i & MASK;
            end
            if (wr_en_i) begin
                en_q <= wdata_i & MASK;
            end
        end
    end

    assign edges = ((cond_i & MASK & ~cond_q) & rise_q)
        | ((~cond_i & cond_q) & fall_q);

    // New edge wins over a clearing read in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            evt_q <= 16'h0000;
        end else begin
            evt_q <= (rd_evt_i ? 16'h0000 : evt_q) | edges;
        end
    end

    assign summary_o = |(evt_q & en_q);

    // Register copies for the top-level read mux
    assign cond_o = cond_q;
    assign rise_o = rise_q;
    assign fall_o = fall_q;
    assign evt_o = evt_q;
    assign en_o = en_q;
endmodule // isr_group

module isr_top
    import isr_pkg::*;
#(
    parameter int OQ_DEPTH_P = isr_pkg::OQ_DEPTH
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic [15:0] NORM_COND_I,
    input wire logic [15:0] ABN_COND_I,
    input wire logic [7:0] STD_EVENT_I,
    input wire logic POWER_ON_CLEAR_I,
    input wire isr_pkg::isr_cmd_t CMD_I,
    input wire logic OQ_PUSH_I,
    input wire logic [7:0] OQ_DATA_I,
    output isr_pkg::isr_rsp_t RSP_O,
    output logic SRQ_O,
    output logic OQ_FULL_O
);
    import isr_pkg::*;

    localparam int CNT_W = $clog2(OQ_DEPTH_P + 1);
    localparam int PTR_W = $clog2(OQ_DEPTH_P);
    localparam logic [CNT_W-1:0] OQ_LAST = CNT_W'(OQ_DEPTH_P - 1);
    localparam logic [CNT_W-1:0] OQ_FULL_CNT = CNT_W'(OQ_DEPTH_P);

    logic [15:0] norm_cond, norm_rise, norm_fall, norm_evt, norm_en;
    logic [15:0] abn_cond, abn_rise, abn_fall, abn_evt, abn_en;
    logic norm_sum, abn_sum, event_summary, message_available;
    logic service_summary_live, service_live_prev_q;
    logic service_request_latched_q;
    logic [7:0] std_evt_q, std_en_q, sre_q;
    logic [7:0] status_base, status_live, status_poll;
    logic acc, wr, rd_norm, rd_abn, rd_std, poll, pop, push;
    logic [BYTE_W-1:0] oq_mem [OQ_DEPTH_P];
    logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    isr_rsp_t rsp_q;
    logic [15:0] rdata;

    assign acc = CMD_I.valid;
    assign wr = acc & CMD_I.write;
    assign rd_norm = acc & !CMD_I.write & (CMD_I.sel == SEL_NORM_EVENT);
    assign rd_abn = acc & !CMD_I.write & (CMD_I.sel == SEL_ABN_EVENT);
    assign rd_std = acc & !CMD_I.write & (CMD_I.sel == SEL_STD_EVENT);
    assign poll = acc & !CMD_I.write & (CMD_I.sel == SEL_POLL);
    assign pop = acc & !CMD_I.write & (CMD_I.sel == SEL_OQ_READ)
        & (cnt_q != '0);
    assign push = OQ_PUSH_I & (cnt_q != OQ_FULL_CNT);

    isr_group #(.MASK(NORM_MASK)) u_norm (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RST_N_I),
        .cond_i(NORM_COND_I),
        .wr_rise_i(wr & (CMD_I.sel == SEL_NORM_RISE)),
        .wr_fall_i(wr & (CMD_I.sel == SEL_NORM_FALL)),
        .wr_en_i(wr & (CMD_I.sel == SEL_NORM_EN)),
        .wdata_i(CMD_I.wdata),
        .rd_evt_i(rd_norm),
        .cond_o(norm_cond),
        .rise_o(norm_rise),
        .fall_o(norm_fall),
        .evt_o(norm_evt),
        .en_o(norm_en),
        .summary_o(norm_sum)
    );

    isr_group #(.MASK(ABN_MASK)) u_abn (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RST_N_I),
        .cond_i(ABN_COND_I),
        .wr_rise_i(wr & (CMD_I.sel == SEL_ABN_RISE)),
        .wr_fall_i(wr & (CMD_I.sel == SEL_ABN_FALL)),
        .wr_en_i(wr & (CMD_I.sel == SEL_ABN_EN)),
        .wdata_i(CMD_I.wdata),
        .rd_evt_i(rd_abn),
        .cond_o(abn_cond),
        .rise_o(abn_rise),
        .fall_o(abn_fall),
        .evt_o(abn_evt),
        .en_o(abn_en),
        .summary_o(abn_sum)
    );

    // Power-on flag set by reset; live events win over the clearing read
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            std_evt_q <= ZERO8;
            std_evt_q[POWER_ON_FLAG_BIT] <= 1'b1;
        end else begin
            std_evt_q <= (rd_std ? ZERO8 : std_evt_q)
                | (STD_EVENT_I & STD_MASK);
        end
    end

    // Enable survives reset when power-on clear is off (nonvolatile copy)
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            if (POWER_ON_CLEAR_I) begin
                std_en_q <= ZERO8;
            end
        end else if (wr & (CMD_I.sel == SEL_STD_EN)) begin
            std_en_q <= CMD_I.wdata[7:0] & STD_MASK;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            sre_q <= ZERO8;
        end else if (wr & (CMD_I.sel == SEL_SRE)) begin
            sre_q <= CMD_I.wdata[7:0] & SRE_MASK;
        end
    end

    assign event_summary = |(std_evt_q & std_en_q);
    assign message_available = (cnt_q != '0);

    // Base byte has no bit 6, so the live summary cannot loop into itself
    always_comb begin
        status_base = ZERO8;
        status_base[STATUS_ABNORMAL_BIT] = abn_sum;
        status_base[STATUS_MESSAGE_BIT] = message_available;
        status_base[STATUS_EVENT_BIT] = event_summary;
        status_base[STATUS_OPERATION_BIT] = norm_sum;
        status_live = status_base;
        status_live[STATUS_SERVICE_BIT] = service_summary_live;
        status_poll = status_base;
        status_poll[STATUS_SERVICE_BIT] = service_request_latched_q;
    end

    assign service_summary_live = |(status_base & sre_q);

    // Request raised when the live summary rises from zero; set wins over the poll clear
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            service_live_prev_q <= 1'b0;
            service_request_latched_q <= 1'b0;
        end else begin
            service_live_prev_q <= service_summary_live;
            service_request_latched_q <= (service_request_latched_q & !poll)
                | (service_summary_live & !service_live_prev_q);
        end
    end

    assign SRQ_O = service_request_latched_q;

    // Output queue storage, no reset needed on the data array
    always_ff @(posedge SYS_CLK_I) begin
        if (push) begin
            oq_mem[wr_ptr_q] <= OQ_DATA_I;
        end
    end

    always_comb begin
        cnt_d = cnt_q;
        if (push & !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop & !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
            OQ_FULL_O <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= (CNT_W'(wr_ptr_q) == OQ_LAST) ? '0
                    : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (CNT_W'(rd_ptr_q) == OQ_LAST) ? '0
                    : rd_ptr_q + 1'b1;
            end
            cnt_q <= cnt_d;
            OQ_FULL_O <= (cnt_d == OQ_FULL_CNT);
        end
    end

    always_comb begin
        rdata = ZERO16;
        unique case (CMD_I.sel)
            SEL_NORM_COND: rdata = norm_cond;
            SEL_NORM_RISE: rdata = norm_rise;
            SEL_NORM_FALL: rdata = norm_fall;
            SEL_NORM_EVENT: rdata = norm_evt;
            SEL_NORM_EN: rdata = norm_en;
            SEL_ABN_COND: rdata = abn_cond;
            SEL_ABN_RISE: rdata = abn_rise;
            SEL_ABN_FALL: rdata = abn_fall;
            SEL_ABN_EVENT: rdata = abn_evt;
            SEL_ABN_EN: rdata = abn_en;
            SEL_STD_EVENT: rdata = {ZERO8, std_evt_q};
            SEL_STD_EN: rdata = {ZERO8, std_en_q};
            SEL_STATUS: rdata = {ZERO8, status_live};
            SEL_SRE: rdata = {ZERO8, sre_q};
            SEL_OQ_READ: rdata = message_available
                ? {ZERO8, oq_mem[rd_ptr_q]} : ZERO16;
            SEL_POLL: rdata = {ZERO8, status_poll};
        endcase
    end

    // Reads answer one cycle later; writes produce no answer
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            rsp_q <= '0;
        end else begin
            rsp_q.valid <= acc & !CMD_I.write;
            rsp_q.data <= (acc & !CMD_I.write) ? rdata : ZERO16;
        end
    end

    assign RSP_O = rsp_q;

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);

    logic rd_status;
    assign rd_status = acc & !CMD_I.write & (CMD_I.sel == SEL_STATUS);

    a_norm_summary_bit: assert property (rd_status |=>
        RSP_O.data[STATUS_OPERATION_BIT] == $past(|(norm_evt & norm_en)))
        else $error("operation summary wrong in status byte");
    a_abn_summary_bit: assert property (rd_status |=>
        RSP_O.data[STATUS_ABNORMAL_BIT] == $past(|(abn_evt & abn_en)))
        else $error("abnormal summary wrong in status byte");
    // Sample taken in reset is zero, so the check starts one cycle later
    a_cond_mirror: assert property (
        acc && !CMD_I.write && CMD_I.sel == SEL_NORM_COND && $past(RST_N_I)
        |=> RSP_O.data == $past(NORM_COND_I & NORM_MASK, 2))
        else $error("condition read does not mirror input");
    a_rise_latch: assert property (
        ((NORM_COND_I & ~norm_cond & norm_rise) != ZERO16)
        |=> (norm_evt & $past(NORM_COND_I & ~norm_cond & norm_rise))
            == $past(NORM_COND_I & ~norm_cond & norm_rise))
        else $error("rising edge not latched");
    a_fall_latch: assert property (
        ((~ABN_COND_I & abn_cond & abn_fall) != ZERO16)
        |=> (abn_evt & $past(~ABN_COND_I & abn_cond & abn_fall)) != ZERO16)
        else $error("falling edge not latched");
    a_read_clears: assert property (
        rd_norm && NORM_COND_I == norm_cond |=> norm_evt == ZERO16)
        else $error("event register not cleared by read");
    a_std_clear: assert property (
        rd_std && STD_EVENT_I == ZERO8 |=> std_evt_q == ZERO8 && RSP_O.valid)
        else $error("standard event not cleared by read");
    a_power_on_flag: assert property (
        $rose(RST_N_I) |-> std_evt_q[POWER_ON_FLAG_BIT])
        else $error("power-on flag missing after reset");
    a_status_keeps: assert property (
        service_request_latched_q && rd_status |=> service_request_latched_q)
        else $error("status byte read cleared request");
    a_request_raise: assert property (
        $rose(service_summary_live) |=> SRQ_O)
        else $error("service request not raised");
    a_poll_clear: assert property (
        poll && !(service_summary_live && !service_live_prev_q) |=> !SRQ_O
        && RSP_O.data[STATUS_SERVICE_BIT] == $past(service_request_latched_q))
        else $error("serial poll did not return and clear request");
    a_queue_flag: assert property (rd_status |=>
        RSP_O.data[STATUS_MESSAGE_BIT] == ($past(cnt_q) != '0))
        else $error("message available flag wrong");
    a_unassigned_zero: assert property (
        (norm_evt & ~NORM_MASK) == ZERO16 && (abn_en & ~ABN_MASK) == ZERO16
        && (sre_q & ~SRE_MASK) == ZERO8)
        else $error("unassigned bit became set");

    c_request_raised: cover property ($rose(SRQ_O));
    c_poll_served: cover property (SRQ_O ##1 poll ##1 !SRQ_O);
    c_both_edges: cover property (norm_rise[NORM_POS_CURRENT_BIT]
        && norm_fall[NORM_POS_CURRENT_BIT]
        && $fell(norm_cond[NORM_POS_CURRENT_BIT]));
    c_queue_full: cover property ($rose(OQ_FULL_O));
endmodule // isr_top

// ---- tb/isr_ctl_model.sv ----
// Controller model: issues register reads and writes on the command port.
// Assumes the design registers the answer to a read on the take edge itself.
`timescale 1ns/100ps
module isr_ctl_model
    import isr_pkg::*;
(
    input wire logic clk_i,
    input wire isr_pkg::isr_rsp_t rsp_i,
    output isr_pkg::isr_cmd_t cmd_o
);
    initial begin
        cmd_o = '0;
    end

    task automatic wr(input isr_sel_t sel, input logic [15:0] d);
        @(posedge clk_i);
        cmd_o <= '{valid: 1'b1, write: 1'b1, sel: sel, wdata: d};
        @(posedge clk_i);
        cmd_o <= '0;
    endtask

    // Serial poll is a plain read of the poll select
    task automatic rd(input isr_sel_t sel, output logic [15:0] d);
        @(posedge clk_i);
        cmd_o <= '{valid: 1'b1, write: 1'b0, sel: sel, wdata: ZERO16};
        @(posedge clk_i);
        cmd_o <= '0;
        #1;
        // Late or missing answer gives unknown, so any compare fails
        d = (rsp_i.valid === 1'b1) ? rsp_i.data : 16'hXXXX;
    endtask
endmodule // isr_ctl_model

// ---- tb/isr_top_tb.sv ----
// Self-checking bench for the status reporting block.
// Assumes the controller model drives the command port.
`timescale 1ns/100ps
module isr_top_tb;
    import isr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] norm_cond = 16'h0000;
    logic [15:0] abn_cond = 16'h0000;
    logic [7:0] std_ev = 8'h00;
    logic poc = 1'b1;
    logic oq_push = 1'b0;
    logic [7:0] oq_data = 8'h00;
    isr_cmd_t cmd;
    isr_rsp_t rsp;
    logic srq;
    logic oq_full;
    logic [15:0] v;
    int err_count = 0;
    int num_checks = 0;
    isr_sel_t sels [8] = '{SEL_NORM_RISE, SEL_NORM_FALL, SEL_NORM_EN,
        SEL_ABN_RISE, SEL_ABN_FALL, SEL_ABN_EN, SEL_STD_EN, SEL_SRE};
    logic [15:0] masks [8] = '{NORM_MASK, NORM_MASK, NORM_MASK, ABN_MASK,
        ABN_MASK, ABN_MASK, {8'h00, STD_MASK}, {8'h00, SRE_MASK}};

    // Small queue depth so the full flag is reachable quickly
    isr_top #(.OQ_DEPTH_P(4)) isr_top_i (
        .SYS_CLK_I(clk), .RST_N_I(rst_n), .NORM_COND_I(norm_cond),
        .ABN_COND_I(abn_cond), .STD_EVENT_I(std_ev),
        .POWER_ON_CLEAR_I(poc), .CMD_I(cmd), .OQ_PUSH_I(oq_push),
        .OQ_DATA_I(oq_data), .RSP_O(rsp), .SRQ_O(srq), .OQ_FULL_O(oq_full)
    );
    isr_ctl_model isr_ctl_model_i (.clk_i(clk), .rsp_i(rsp), .cmd_o(cmd));

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    // Event shows one cycle after the edge; three cycles is margin
    task automatic cond(input logic [15:0] o, input logic [15:0] a);
        @(posedge clk);
        norm_cond <= o;
        abn_cond <= a;
        repeat (3) @(posedge clk);
    endtask

    task automatic rdc(input isr_sel_t s, input logic [15:0] exp);
        isr_ctl_model_i.rd(s, v);
        chk(v, exp);
    endtask

    task automatic push(input logic [7:0] b);
        @(posedge clk);
        oq_push <= 1'b1;
        oq_data <= b;
        @(posedge clk);
        oq_push <= 1'b0;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdc(SEL_STD_EVENT, 16'h0080);
        rdc(SEL_STD_EVENT, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            isr_ctl_model_i.wr(sels[i], 16'hFFFF);
            rdc(sels[i], masks[i]);
            isr_ctl_model_i.wr(sels[i], 16'h0000);
        end
        // Live conditions, unassigned bits dropped, writes refused
        cond(16'hFFFF, 16'hFFFF);
        rdc(SEL_NORM_COND, NORM_MASK);
        isr_ctl_model_i.wr(SEL_ABN_COND, 16'h0000);
        rdc(SEL_ABN_COND, ABN_MASK);
        rdc(SEL_NORM_EVENT, 16'h0000);
        cond(16'h0000, 16'h0000);
        // Edge filters per bit
        isr_ctl_model_i.wr(SEL_NORM_RISE, 16'h0400);
        isr_ctl_model_i.wr(SEL_NORM_FALL, 16'h0800);
        cond(16'h0C00, 16'h0000);
        rdc(SEL_NORM_EVENT, 16'h0400);
        rdc(SEL_NORM_EVENT, 16'h0000);
        cond(16'h0000, 16'h0000);
        rdc(SEL_NORM_EVENT, 16'h0800);
        // Both filters, summary, latched request and serial poll
        isr_ctl_model_i.wr(SEL_NORM_FALL, 16'h0400);
        isr_ctl_model_i.wr(SEL_NORM_EN, 16'h0400);
        isr_ctl_model_i.wr(SEL_SRE, 16'h0080);
        cond(16'h0400, 16'h0000);
        rdc(SEL_STATUS, 16'h00C0);
        chk({15'h0000, srq}, 16'h0001);
        rdc(SEL_POLL, 16'h00C0);
        chk({15'h0000, srq}, 16'h0000);
        rdc(SEL_POLL, 16'h0080);
        rdc(SEL_NORM_EVENT, 16'h0400);
        rdc(SEL_STATUS, 16'h0000);
        cond(16'h0000, 16'h0000);
        rdc(SEL_STATUS, 16'h00C0);
        rdc(SEL_NORM_EVENT, 16'h0400);
        rdc(SEL_POLL, 16'h0040);
        // Abnormal group with binary weighted masks
        isr_ctl_model_i.wr(SEL_ABN_RISE, 16'h0013);
        isr_ctl_model_i.wr(SEL_ABN_EN, 16'h0013);
        isr_ctl_model_i.wr(SEL_SRE, 16'h0088);
        cond(16'h0000, 16'h0014);
        rdc(SEL_STATUS, 16'h0048);
        chk({15'h0000, srq}, 16'h0001);
        rdc(SEL_ABN_EVENT, 16'h0010);
        rdc(SEL_STATUS, 16'h0000);
        rdc(SEL_POLL, 16'h0040);
        // Standard event group
        isr_ctl_model_i.wr(SEL_STD_EN, 16'h0020);
        isr_ctl_model_i.wr(SEL_SRE, 16'h0020);
        @(posedge clk);
        std_ev <= 8'hFF;
        @(posedge clk);
        std_ev <= 8'h00;
        rdc(SEL_STATUS, 16'h0060);
        rdc(SEL_STD_EVENT, {8'h00, STD_MASK});
        rdc(SEL_STD_EVENT, 16'h0000);
        rdc(SEL_POLL, 16'h0040);
        // Output queue order, full refusal and empty read
        for (int i = 1; i <= 5; i++) push(8'(i * 17));
        chk({15'h0000, oq_full}, 16'h0001);
        rdc(SEL_STATUS, 16'h0010);
        for (int i = 1; i <= 4; i++) rdc(SEL_OQ_READ, 16'(i * 17));
        rdc(SEL_OQ_READ, 16'h0000);
        rdc(SEL_STATUS, 16'h0000);
        chk({15'h0000, oq_full}, 16'h0000);
        // Power-on flag and retained standard enable
        isr_ctl_model_i.wr(SEL_STD_EN, 16'h0080);
        poc <= 1'b0;
        reset();
        rdc(SEL_STD_EN, 16'h0080);
        isr_ctl_model_i.wr(SEL_SRE, 16'h0020);
        rdc(SEL_STATUS, 16'h0060);
        chk({15'h0000, srq}, 16'h0001);
        // Read returns off the edge; realign before touching inputs
        @(posedge clk);
        poc <= 1'b1;
        reset();
        rdc(SEL_STD_EN, 16'h0000);
        wrap_up();
    end
endmodule // isr_top_tb
